/* File: logic/rcl_loader.sv */
// Reset-time loader that copies flash configuration words into volatile registers.
`timescale 1ns/1ps
module rcl_loader
	import rcl_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    clk_en,
	input  wire logic [1:0]              mem_size,
	output logic                         flash_rd,
	output rcl_pkg::rcl_addr_t           flash_addr,
	input  wire logic [rcl_pkg::WORD_W-1:0] flash_rdata,
	input  wire logic                    tbl_rd,
	input  wire logic                    fetch_rd,
	input  wire rcl_pkg::rcl_addr_t      cpu_addr,
	output logic [rcl_pkg::CFG_W-1:0]    cfg_rdata,
	output logic                         cfg_hit,
	output logic                         access_err,
	output logic                         core_rst_n,
	output logic                         cfg_valid
);
	import rcl_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rcl_state_e                state;
		logic [1:0]                lat;
		logic [LOW_W-1:0]          w1;
		logic [LOW_W-1:0]          w2;
		logic [NREG*CFG_W-1:0]     cfg;
		logic                      rd;
		rcl_addr_t                 addr;
		logic [CFG_W-1:0]          rdata;
		logic                      hit;
		logic                      err;
		logic                      core_n;
		logic                      valid;
	} rcl_st_s;

	rcl_st_s s_r;
	rcl_st_s s_nxt;

	logic [NREG*CFG_W-1:0] unpacked;
	rcl_addr_t             w1_addr;
	rcl_addr_t             rel;
	logic [IDX_W-1:0]      idx;

	rcl_unpack u_unpack (
		.word1_lo (s_r.w1),
		.word2_lo (s_r.w2),
		.cfg_flat (unpacked)
	);

	// ----------------------------------------------------------------
	// Source addresses
	// ----------------------------------------------------------------
	always_comb begin
		case (mem_size)
			2'h0: w1_addr = W1_ADDR_S0;
			2'h1: w1_addr = W1_ADDR_S1;
			2'h2: w1_addr = W1_ADDR_S2;
			default: w1_addr = W1_ADDR_S3;
		endcase
	end

	assign rel = cpu_addr - CFG_BASE;
	assign idx = rel[IDX_W:1];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rd = 1'b0;
		s_nxt.hit = 1'b0;
		s_nxt.err = 1'b0;
		case (s_r.state)
			RCL_IDLE: begin
				s_nxt.state = RCL_REQ1;
			end
			RCL_REQ1: begin
				s_nxt.rd = 1'b1;
				s_nxt.addr = w1_addr;
				s_nxt.lat = FLASH_LAT_C;
				s_nxt.state = RCL_WAIT1;
			end
			RCL_WAIT1: begin
				if (s_r.lat != 2'h0) begin
					s_nxt.lat = s_r.lat - 2'h1;
				end else begin
					s_nxt.w1 = flash_rdata[LOW_W-1:0];
					s_nxt.state = RCL_REQ2;
				end
			end
			RCL_REQ2: begin
				s_nxt.rd = 1'b1;
				s_nxt.addr = w1_addr - WORD2_DELTA;
				s_nxt.lat = FLASH_LAT_C;
				s_nxt.state = RCL_WAIT2;
			end
			RCL_WAIT2: begin
				if (s_r.lat != 2'h0) begin
					s_nxt.lat = s_r.lat - 2'h1;
				end else begin
					s_nxt.w2 = flash_rdata[LOW_W-1:0];
					s_nxt.state = RCL_DONE;
				end
			end
			RCL_DONE: begin
				s_nxt.cfg = unpacked;
				s_nxt.valid = 1'b1;
				s_nxt.core_n = 1'b1;
				// Only table reads reach configuration space. They are refused until the copy
				// has landed, so an erased value never leaks out on the first done cycle.
				if (s_r.valid && tbl_rd && cpu_addr >= CFG_BASE && rel < NREG * CFG_STRIDE) begin
					s_nxt.hit = 1'b1;
					s_nxt.rdata = s_r.cfg[idx*CFG_W +: CFG_W];
				end
				if (fetch_rd && cpu_addr >= CFG_SPACE_LO) begin
					s_nxt.err = 1'b1;
				end
			end
			default: s_nxt.state = RCL_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset reloads on every cause: the core is held and the registers read erased.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r.state  <= RCL_IDLE;
			s_r.lat    <= 2'h0;
			s_r.w1     <= CFG_ERASED;
			s_r.w2     <= CFG_ERASED;
			s_r.cfg    <= {NREG{CFG_ERASED}};
			s_r.rd     <= 1'b0;
			s_r.addr   <= '0;
			s_r.rdata  <= '0;
			s_r.hit    <= 1'b0;
			s_r.err    <= 1'b0;
			s_r.core_n <= 1'b0;
			s_r.valid  <= 1'b0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign flash_rd   = s_r.rd;
	assign flash_addr = s_r.addr;
	assign cfg_rdata  = s_r.rdata;
	assign cfg_hit    = s_r.hit;
	assign access_err = s_r.err;
	assign core_rst_n = s_r.core_n;
	assign cfg_valid  = s_r.valid;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence word1_req_s;
		flash_rd && flash_addr == w1_addr;
	endsequence
	sequence word2_req_s;
		flash_rd && flash_addr == w1_addr - WORD2_DELTA;
	endsequence

	core_hold_a: assert property (core_rst_n |-> cfg_valid)
		else $error("core released before configuration loaded");
	load_order_a: assert property ((clk_en ##0 word1_req_s) |=> ##[1:20] word2_req_s)
		else $error("word 2 not fetched after word 1");
	addr_first_a: assert property ($rose(flash_rd) && !$past(s_r.w1 != CFG_ERASED)
		|-> flash_addr == w1_addr || flash_addr == w1_addr - WORD2_DELTA)
		else $error("fetch outside configuration words");
	valid_stick_a: assert property (cfg_valid |=> cfg_valid)
		else $error("valid dropped without reset");
	tbl_only_a: assert property (cfg_hit |-> $past(tbl_rd))
		else $error("config space hit without table read");
	fetch_err_a: assert property (clk_en && cfg_valid && fetch_rd && cpu_addr >= CFG_SPACE_LO
		|=> access_err)
		else $error("fetch into config space not flagged");
	base_map_a: assert property (clk_en && cfg_valid && tbl_rd && cpu_addr == CFG_BASE
		|=> cfg_hit && cfg_rdata == $past(s_r.cfg[CFG_W-1:0]))
		else $error("base register not returned at base address");
	upper_ign_a: assert property (cfg_valid |-> s_r.cfg[4*CFG_W +: CFG_W] == (s_r.w1 & s_r.w2))
		else $error("fifth register not from low halves");
	erased_a: assert property (!cfg_valid |-> s_r.cfg == {NREG{CFG_ERASED}})
		else $error("registers not erased before load");

	// ----------------------------------------------------------------
	// Request shape and refusals
	// ----------------------------------------------------------------
	// A read request is a single enabled cycle; a held request would let the
	// flash restart its latency count and deliver the word one cycle late.
	sequence rd_taken_s;
		clk_en && flash_rd;
	endsequence
	sequence rd_gone_s;
		!flash_rd;
	endsequence
	sequence tbl_early_s;
		clk_en && tbl_rd && !cfg_valid;
	endsequence
	sequence tbl_beyond_s;
		clk_en && tbl_rd && cpu_addr >= CFG_BASE + NREG * CFG_STRIDE;
	endsequence

	rd_pulse_a: assert property (rd_taken_s |=> rd_gone_s)
		else $error("flash read request held past one cycle");
	early_tbl_a: assert property (tbl_early_s |=> !cfg_hit)
		else $error("table read answered before load finished");
	beyond_map_a: assert property (tbl_beyond_s |=> !cfg_hit)
		else $error("table read hit beyond the last register");
	// A frozen clock holds the error flag, so only an enabled cycle is traced back.
	err_src_a: assert property (access_err && $past(clk_en) |-> $past(fetch_rd))
		else $error("access error without a fetch");
endmodule : rcl_loader

/* File: logic/rcl_pkg.sv */
// Constants for the reset-time configuration word loader.
package rcl_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int WORD_W = 24;
	localparam int CFG_W  = 16;
	localparam int LOW_W  = 16;
	localparam int NREG   = 5;
	localparam int IDX_W  = 3;

	typedef logic [ADDR_W-1:0] rcl_addr_t;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam rcl_addr_t CFG_BASE    = 24'hf80000;
	localparam rcl_addr_t CFG_SPACE_LO = 24'h800000;
	localparam rcl_addr_t CFG_STRIDE  = 24'h000002;
	localparam rcl_addr_t WORD2_DELTA = 24'h000002;

	// Word 1 address per memory size code 0..3, word 2 sits two bytes lower.
	localparam rcl_addr_t W1_ADDR_S0 = 24'h002bfe;
	localparam rcl_addr_t W1_ADDR_S1 = 24'h0057fe;
	localparam rcl_addr_t W1_ADDR_S2 = 24'h0083fe;
	localparam rcl_addr_t W1_ADDR_S3 = 24'h00abfe;

	// Value of an erased (unprogrammed) configuration register.
	localparam logic [CFG_W-1:0] CFG_ERASED = 16'hffff;

	// Flash read latency in cycles before rdata is valid.
	localparam int FLASH_LAT = 2;
	localparam logic [1:0] FLASH_LAT_C = 2'h2;

	typedef enum logic [2:0] {
		RCL_IDLE,
		RCL_REQ1,
		RCL_WAIT1,
		RCL_REQ2,
		RCL_WAIT2,
		RCL_DONE
	} rcl_state_e;

endpackage : rcl_pkg

/* File: logic/rcl_unpack.sv */
// Unpacks the two low halves of the configuration words into five registers.
`timescale 1ns/1ps
module rcl_unpack
	import rcl_pkg::*;
(
	input  wire logic [rcl_pkg::LOW_W-1:0] word1_lo,
	input  wire logic [rcl_pkg::LOW_W-1:0] word2_lo,
	output logic [rcl_pkg::NREG*rcl_pkg::CFG_W-1:0] cfg_flat
);
	// Field spread is unspecified, so each of the first four registers takes one byte of packed data
	// padded with ones, keeping unused bits at the unprogrammed level.
	logic [4*8-1:0] bytes;
	assign bytes = {word2_lo, word1_lo};

	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			if (g < 4) begin : g_b
				assign cfg_flat[g*CFG_W +: CFG_W] = {8'hff, bytes[g*8 +: 8]};
			end else begin : g_x
				// Fifth location: combined bitwise AND of both words.
				assign cfg_flat[g*CFG_W +: CFG_W] = word1_lo & word2_lo;
			end
		end
	endgenerate
endmodule : rcl_unpack

/* File: tb/rcl_flash_model.sv */
// Behavioural flash that holds the two packed configuration words.
`timescale 1ns/1ps
module rcl_flash_model
	import rcl_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       clk_en,
	input  wire logic                       flash_rd,
	input  wire rcl_pkg::rcl_addr_t         flash_addr,
	input  wire rcl_pkg::rcl_addr_t         w1_addr,
	input  wire logic [rcl_pkg::WORD_W-1:0] word1,
	input  wire logic [rcl_pkg::WORD_W-1:0] word2,
	output logic [rcl_pkg::WORD_W-1:0]      flash_rdata
);
	import rcl_pkg::*;
	logic [1:0]        lat_r = 2'h0;
	rcl_addr_t         addr_r = 24'h000000;
	logic [WORD_W-1:0] word;
	always @(posedge mclk) begin
		if (clk_en && flash_rd) begin
			lat_r <= FLASH_LAT_C;
			addr_r <= flash_addr;
		end else if (clk_en && lat_r != 2'h0) begin
			lat_r <= lat_r - 2'h1;
		end
	end
	// Only the two top words hold configuration data; the rest is code.
	// Outside the single valid cycle the bus shows the inverse, so a mistimed sample is caught.
	always_comb begin
		word = (addr_r == w1_addr) ? word1 :
			(addr_r == w1_addr - WORD2_DELTA) ? word2 : 24'h5a5a5a;
		flash_rdata = (lat_r == 2'h1) ? word : ~word;
	end
endmodule : rcl_flash_model

/* File: tb/reset_config_word_loader_tb_top.sv */
// Self-checking bench for the reset-time configuration word loader.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: %h %h", $time, g, e); end end
module reset_config_word_loader_tb_top;
	import rcl_pkg::*;
	logic        mclk, rst_n, clk_en, tbl_rd, fetch_rd, flash_rd, cfg_hit, access_err;
	logic        core_rst_n, cfg_valid;
	logic [1:0]  mem_size;
	rcl_addr_t   cpu_addr, flash_addr, w1a;
	logic [23:0] w1, w2, rdata;
	logic [15:0] cfg_rdata;
	logic [16:0] hq[$];
	logic [16:0] got_h, exp_h;
	rcl_addr_t   exp_a;
	rcl_addr_t   aq[$];
	int          n_fail = 0, cmp_count = 0, cyc = 0, seed, r, n;

	rcl_loader i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .mem_size(mem_size),
		.flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(rdata), .tbl_rd(tbl_rd),
		.fetch_rd(fetch_rd), .cpu_addr(cpu_addr), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
		.access_err(access_err), .core_rst_n(core_rst_n), .cfg_valid(cfg_valid));
	rcl_flash_model i_flash (.mclk(mclk), .clk_en(clk_en), .flash_rd(flash_rd),
		.flash_addr(flash_addr), .w1_addr(w1a), .word1(w1), .word2(w2), .flash_rdata(rdata));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test

	task step;
		@(posedge mclk);
		#2;
	endtask : step

	// One request cycle, then idle; a noted answer is checked by the monitor.
	task automatic acc(input logic f, input rcl_addr_t a, input logic ex, input logic [15:0] d);
		step;
		tbl_rd = !f;
		fetch_rd = f;
		cpu_addr = a;
		if (ex) hq.push_back({f, f ? 16'h0000 : d});
		step;
		tbl_rd = 1'b0;
		fetch_rd = 1'b0;
	endtask : acc

	function automatic logic [15:0] ev(int k);
		logic [31:0] b;
		b = {w2[15:0], w1[15:0]};
		return (k < 4) ? {8'hff, b[8*k+:8]} : (w1[15:0] & w2[15:0]);
	endfunction : ev

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			finish_test;
		end
		`CHK(core_rst_n, cfg_valid)
		// The oldest note is taken once into a variable, so a mismatch report cannot pop again.
		if (clk_en && flash_rd) begin
			exp_a = aq.size() ? aq.pop_front() : ~flash_addr;
			`CHK(flash_addr, exp_a)
		end
		if (cfg_hit || access_err) begin
			got_h = {access_err, access_err ? 16'h0000 : cfg_rdata};
			exp_h = hq.size() ? hq.pop_front() : ~got_h;
			`CHK(got_h, exp_h)
		end
	end

	initial begin
		seed = 14815;
		{rst_n, clk_en, tbl_rd, fetch_rd, mem_size, cpu_addr, w1, w2} = '0;
		for (r = 0; r < 5; r++) begin
			w1 = $random(seed);
			w2 = $random(seed);
			if (r < 4) {w1[23:16], w2[23:16]} = 16'hffff;
			if (r == 3) {w1[15:0], w2[15:0]} = 32'hffffffff;
			mem_size = (r > 3) ? 2'h3 : r[1:0];
			w1a = (mem_size == 2'h0) ? W1_ADDR_S0 : (mem_size == 2'h1) ? W1_ADDR_S1 :
				(mem_size == 2'h2) ? W1_ADDR_S2 : W1_ADDR_S3;
			aq.push_back(w1a);
			aq.push_back(w1a - WORD2_DELTA);
			rst_n = 1'b0;
			repeat (2) step;
			rst_n = 1'b1;
			cpu_addr = CFG_BASE;
			for (n = 0; n < 200 && !cfg_valid; n++) begin
				tbl_rd = $random(seed);
				clk_en = $random(seed);
				step;
			end
			{tbl_rd, clk_en} = 2'h1;
			`CHK(cfg_valid, 1'b1)
			for (n = 0; n < 10; n++) acc(1'b0, CFG_BASE + n, 1'b1, ev(n / 2));
			acc(1'b0, CFG_BASE + 24'h00000a, 1'b0, 16'h0000);
			acc(1'b1, CFG_SPACE_LO, 1'b1, 16'h0000);
			acc(1'b1, 24'hfffffe, 1'b1, 16'h0000);
			acc(1'b1, CFG_BASE, 1'b1, 16'h0000);
			acc(1'b1, 24'h7ffffe, 1'b0, 16'h0000);
			repeat (4) step;
			`CHK(hq.size() + aq.size(), 0)
			$display("round %0d done", r);
		end
		finish_test;
	end
endmodule : reset_config_word_loader_tb_top
